/* File: core/evr_cfg.svh */
`ifndef EVR_CFG_SVH
`define EVR_CFG_SVH
`define EVR_OFF_CTRL 12'h000
`define EVR_OFF_CHAN 12'h004
`define EVR_OFF_USER 12'h008
`define EVR_OFF_STAT 12'h00c
`define EVR_OFF_ENCLR 12'h010
`define EVR_OFF_ENSET 12'h014
`define EVR_OFF_FLAGS 12'h018
`define EVR_CTRL_SOFT_RESET_BIT 0
`define EVR_CTRL_CLKREQ 4
`define EVR_CHAN_SEL_LSB 0
`define EVR_CHAN_SOFT_EVENT_TRIGGER 8
`define EVR_CHAN_GEN_LSB 16
`define EVR_CHAN_EDGE_LSB 26
`define EVR_CHAN_PATH_LSB 24
`define EVR_OVR_LSB 0
`define EVR_EVD_LSB 8
`define EVR_RST_CHAN 32'h0000_0000
`define EVR_RST_USER 16'h0000
`endif

/* File: core/evr_pkg.sv */
package evr_pkg;
	typedef enum logic [1:0] {
		EVR_PATH_SYNC = 2'h0,
		EVR_PATH_RESYNC = 2'h1,
		EVR_PATH_ASYNC = 2'h2,
		EVR_PATH_RSVD = 2'h3
	} evr_path_t;
	typedef enum logic [1:0] {
		EVR_EDGE_NONE = 2'h0,
		EVR_EDGE_RISE = 2'h1,
		EVR_EDGE_FALL = 2'h2,
		EVR_EDGE_BOTH = 2'h3
	} evr_edge_t;
endpackage

/* File: core/evr_irq_status.sv */
// Operation
// - Each channel has overrun and detected flags.
// - Flag sets when its condition occurs.
// - Set/clear registers write-one change enables.
// - Interrupt asserts when flag and enable set.
// - Interrupt holds until clear, disable, reset.
// - All enabled pending sources ORed together.
// - Overrun when users not ready at event.
// - Overrun when previous event still unhandled.
// - No overrun on asynchronous path.
// - Detected flag sets on selected generator event.
// - No detected flag on asynchronous path.
// - Interrupt doubles as asynchronous wake request.
// - Sleep event requests channel clock, no wake.
// - Clock request drops once event handled.
// - Asynchronous path never requests channel clock.
// - Software reset clears registers and events.
// - Always-on bit keeps sync and resync channel clocks requested.
// - Path codes: sync, resync, async, reserved.
// - Status shows busy and users ready.
// - Software reset discards other written bits.
`timescale 1ns/1ps
`include "evr_cfg.svh"
module evr_irq_status #(
	parameter int NCH = 8,
	parameter int NGEN = 256
) (
	// Clock, enable, reset
	input wire logic mclk_i,
	input wire logic ce_i,
	input wire logic arst_n_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Event generators and users
	input wire logic [NGEN-1:0] gen_lvl_i,
	input wire logic [NCH-1:0] users_ready_i,
	input wire logic [NCH-1:0] users_done_i,
	input wire logic sys_clk_stopped_i,
	// Outputs
	output logic [NCH-1:0] chan_event_o,
	output logic [NCH-1:0] chan_clk_req_o,
	output logic irq_o,
	output logic wake_o
);
	localparam int CW = $clog2(NCH);
	logic [NCH-1:0] overrun_flag_r, event_detected_flag_r;
	logic [NCH-1:0] en_ovr_r, en_evd_r;
	logic [NCH-1:0] busy_r, prev_lvl_r;
	logic clock_always_on_request_r;
	logic [7:0] chan_sel_r;
	logic [1:0] path_r [NCH];
	logic [1:0] edge_r [NCH];
	logic [7:0] gen_r [NCH];
	logic [15:0] user_mux_r;
	logic [NCH-1:0] det, sync_ch;
	logic wr, rd, soft_reset_bit, cfg_wr, soft_event_trigger;
	assign wr = psel_i && penable_i && pwrite_i && ce_i;
	assign rd = psel_i && !penable_i && !pwrite_i && ce_i;
	assign soft_reset_bit = wr && paddr_i == `EVR_OFF_CTRL && pwdata_i[`EVR_CTRL_SOFT_RESET_BIT];
	assign cfg_wr = wr && paddr_i == `EVR_OFF_CHAN;
	assign soft_event_trigger = cfg_wr && pwdata_i[`EVR_CHAN_SOFT_EVENT_TRIGGER];

	// Generator zero means no generator, so it never produces an edge.
	function automatic logic sel_level(input logic [7:0] g, input logic [NGEN-1:0] lv);
		return g == 8'h00 ? 1'b0 : lv[g];
	endfunction

	function automatic logic path_sync(input logic [1:0] p);
		return p == evr_pkg::EVR_PATH_SYNC || p == evr_pkg::EVR_PATH_RESYNC;
	endfunction

	// Edge detection on the selected generator; channel index gated by path.
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			logic lv;
			logic rise;
			logic fall;
			lv = sel_level(gen_r[c], gen_lvl_i);
			rise = lv && !prev_lvl_r[c];
			fall = !lv && prev_lvl_r[c];
			sync_ch[c] = path_sync(path_r[c]);
			det[c] = 1'b0;
			unique case (edge_r[c])
				evr_pkg::EVR_EDGE_NONE: det[c] = 1'b0;
				evr_pkg::EVR_EDGE_RISE: det[c] = rise;
				evr_pkg::EVR_EDGE_FALL: det[c] = fall;
				evr_pkg::EVR_EDGE_BOTH: det[c] = rise || fall;
			endcase
			if (soft_event_trigger && pwdata_i[CW-1:0] == CW'(c) && pwdata_i[7:CW] == '0)
				det[c] = 1'b1;
			det[c] = det[c] && sync_ch[c];
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prev_lvl_r <= '0;
		end else if (ce_i) begin
			for (int c = 0; c < NCH; c++)
				prev_lvl_r[c] <= sel_level(gen_r[c], gen_lvl_i);
		end
	end

	// Configuration registers. A soft reset also cancels in-flight events.
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			clock_always_on_request_r <= 1'b0;
			chan_sel_r <= 8'h00;
			user_mux_r <= `EVR_RST_USER;
			for (int c = 0; c < NCH; c++) begin
				path_r[c] <= 2'h0;
				edge_r[c] <= 2'h0;
				gen_r[c] <= 8'h00;
			end
		end else if (ce_i) begin
			if (soft_reset_bit) begin
				clock_always_on_request_r <= 1'b0;
				chan_sel_r <= 8'h00;
				user_mux_r <= `EVR_RST_USER;
				for (int c = 0; c < NCH; c++) begin
					path_r[c] <= 2'h0;
					edge_r[c] <= 2'h0;
					gen_r[c] <= 8'h00;
				end
			end else if (wr) begin
				if (paddr_i == `EVR_OFF_CTRL)
					clock_always_on_request_r <= pwdata_i[`EVR_CTRL_CLKREQ];
				if (paddr_i == `EVR_OFF_USER)
					user_mux_r <= pwdata_i[15:0];
				if (cfg_wr) begin
					chan_sel_r <= pwdata_i[7:0];
					if (pwdata_i[7:0] < 8'(NCH)) begin
						path_r[pwdata_i[CW-1:0]] <= pwdata_i[`EVR_CHAN_PATH_LSB +: 2];
						edge_r[pwdata_i[CW-1:0]] <= pwdata_i[`EVR_CHAN_EDGE_LSB +: 2];
						gen_r[pwdata_i[CW-1:0]] <= pwdata_i[`EVR_CHAN_GEN_LSB +: 8];
					end
				end
			end
		end
	end

	// Enables: write-one set / write-one clear.
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			en_ovr_r <= '0;
			en_evd_r <= '0;
		end else if (ce_i) begin
			if (soft_reset_bit) begin
				en_ovr_r <= '0;
				en_evd_r <= '0;
			end else if (wr && paddr_i == `EVR_OFF_ENSET) begin
				en_ovr_r <= en_ovr_r | pwdata_i[`EVR_OVR_LSB +: NCH];
				en_evd_r <= en_evd_r | pwdata_i[`EVR_EVD_LSB +: NCH];
			end else if (wr && paddr_i == `EVR_OFF_ENCLR) begin
				en_ovr_r <= en_ovr_r & ~pwdata_i[`EVR_OVR_LSB +: NCH];
				en_evd_r <= en_evd_r & ~pwdata_i[`EVR_EVD_LSB +: NCH];
			end
		end
	end

	// Busy tracks an event not yet handled by every user.
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			busy_r <= '0;
		end else if (ce_i) begin
			if (soft_reset_bit)
				busy_r <= '0;
			else
				busy_r <= (busy_r & ~users_done_i | det) & sync_ch;
		end
	end

	// Flags: hardware set wins over a software write-one clear.
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			overrun_flag_r <= '0;
			event_detected_flag_r <= '0;
		end else if (ce_i) begin
			if (soft_reset_bit) begin
				overrun_flag_r <= '0;
				event_detected_flag_r <= '0;
			end else begin
				logic [NCH-1:0] clr_o;
				logic [NCH-1:0] clr_e;
				logic [NCH-1:0] ovr_set;
				clr_o = (wr && paddr_i == `EVR_OFF_FLAGS) ? pwdata_i[`EVR_OVR_LSB +: NCH] : '0;
				clr_e = (wr && paddr_i == `EVR_OFF_FLAGS) ? pwdata_i[`EVR_EVD_LSB +: NCH] : '0;
				ovr_set = det & (~users_ready_i | busy_r);
				overrun_flag_r <= ((overrun_flag_r & ~clr_o) | ovr_set) & sync_ch;
				event_detected_flag_r <= ((event_detected_flag_r & ~clr_e) | det)
					& sync_ch;
			end
		end
	end

	// Interrupt, wake and channel clock request outputs.
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_o <= 1'b0;
			wake_o <= 1'b0;
			chan_clk_req_o <= '0;
			chan_event_o <= '0;
		end else if (ce_i) begin
			logic pend;
			pend = |(overrun_flag_r & en_ovr_r) || |(event_detected_flag_r & en_evd_r);
			irq_o <= pend && !soft_reset_bit;
			wake_o <= pend && !soft_reset_bit;
			chan_event_o <= soft_reset_bit ? '0 : det;
			if (soft_reset_bit)
				chan_clk_req_o <= '0;
			else
				chan_clk_req_o <= sync_ch & ({NCH{clock_always_on_request_r}}
					| det | (busy_r & ~users_done_i));
		end
	end

	// APB read data, prepared in setup so it is registered for access.
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prdata_o <= 32'h0000_0000;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end else if (ce_i) begin
			pready_o <= psel_i && !penable_i;
			pslverr_o <= psel_i && !penable_i && paddr_i > `EVR_OFF_FLAGS;
			if (rd) begin
				prdata_o <= 32'h0000_0000;
				unique case (paddr_i)
					`EVR_OFF_CTRL: prdata_o[`EVR_CTRL_CLKREQ] <= clock_always_on_request_r;
					`EVR_OFF_CHAN: begin
						prdata_o[7:0] <= chan_sel_r;
						if (chan_sel_r < 8'(NCH)) begin
							prdata_o[`EVR_CHAN_PATH_LSB +: 2] <= path_r[chan_sel_r[CW-1:0]];
							prdata_o[`EVR_CHAN_EDGE_LSB +: 2] <= edge_r[chan_sel_r[CW-1:0]];
							prdata_o[`EVR_CHAN_GEN_LSB +: 8] <= gen_r[chan_sel_r[CW-1:0]];
						end
					end
					`EVR_OFF_USER: prdata_o[15:0] <= user_mux_r;
					`EVR_OFF_STAT: begin
						prdata_o[0 +: NCH] <= users_ready_i & sync_ch;
						prdata_o[8 +: NCH] <= busy_r;
					end
					`EVR_OFF_ENCLR, `EVR_OFF_ENSET: begin
						prdata_o[`EVR_OVR_LSB +: NCH] <= en_ovr_r;
						prdata_o[`EVR_EVD_LSB +: NCH] <= en_evd_r;
					end
					`EVR_OFF_FLAGS: begin
						prdata_o[`EVR_OVR_LSB +: NCH] <= overrun_flag_r;
						prdata_o[`EVR_EVD_LSB +: NCH] <= event_detected_flag_r;
					end
					default: prdata_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Checks.
	sequence s_det(int c);
		ce_i && det[c];
	endsequence
	a_flag_set_det: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		ce_i && det[0] && !soft_reset_bit |=> event_detected_flag_r[0])
		else $error("detected flag not set");
	a_async_no_flag: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		ce_i && !sync_ch[0] |=> !overrun_flag_r[0] && !event_detected_flag_r[0])
		else $error("flag set on async path");
	a_irq_or_sources: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		ce_i && !soft_reset_bit && |(event_detected_flag_r & en_evd_r) |=> irq_o)
		else $error("irq missing");
	a_irq_needs_src: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		ce_i && !(|(overrun_flag_r & en_ovr_r)) && !(|(event_detected_flag_r & en_evd_r))
		|=> !irq_o)
		else $error("spurious irq");
	a_enset_works: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		wr && !soft_reset_bit && paddr_i == `EVR_OFF_ENSET && pwdata_i[8] |=> en_evd_r[0])
		else $error("enable not set");
	a_soft_reset_bit_clears: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		soft_reset_bit |=> en_ovr_r == '0 && overrun_flag_r == '0 && !clock_always_on_request_r)
		else $error("soft reset incomplete");
	a_ovr_busy: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		s_det(0) ##0 busy_r[0] && !soft_reset_bit |=> overrun_flag_r[0])
		else $error("overrun missed");
	a_async_noclk: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		ce_i && !sync_ch[1] |=> !chan_clk_req_o[1])
		else $error("clock requested on async");
	a_clk_on_event: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		s_det(0) ##0 sys_clk_stopped_i && !soft_reset_bit |=> chan_clk_req_o[0])
		else $error("no clock request");

	// A software write to the flags, or a register read in its setup cycle.
	sequence s_flag_wr(int b);
		ce_i && wr && paddr_i == `EVR_OFF_FLAGS && pwdata_i[b];
	endsequence
	sequence s_reg_rd(logic [11:0] a);
		ce_i && rd && paddr_i == a;
	endsequence

	a_clk_any_event: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		s_det(0) ##0 !soft_reset_bit |=> chan_clk_req_o[0])
		else $error("event without clock request");
	a_clk_drops: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		ce_i && !soft_reset_bit && !clock_always_on_request_r && !det[0]
		&& !(busy_r[0] && !users_done_i[0]) |=> !chan_clk_req_o[0])
		else $error("clock request kept after event");
	a_always_on: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		ce_i && !soft_reset_bit && clock_always_on_request_r && sync_ch[0] |=> chan_clk_req_o[0])
		else $error("always-on request missing");
	a_async_noclk2: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		ce_i && !sync_ch[2] |=> !chan_clk_req_o[2])
		else $error("clock requested on reserved path");
	a_async_no_det: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		ce_i && !sync_ch[1] |-> !det[1])
		else $error("event detected on async path");
	a_rsvd_path: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		ce_i && path_r[2] == 2'h3 |-> !sync_ch[2])
		else $error("reserved path treated as sync");
	a_ovr_notready: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		s_det(0) ##0 !users_ready_i[0] && !soft_reset_bit |=> overrun_flag_r[0])
		else $error("overrun on not ready missed");
	a_busy_set: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		s_det(0) ##0 !soft_reset_bit |=> busy_r[0])
		else $error("busy not set");
	a_busy_async: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		ce_i && !sync_ch[1] |=> !busy_r[1])
		else $error("busy on async path");
	a_event_out: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		s_det(0) ##0 !soft_reset_bit |=> chan_event_o[0])
		else $error("event not forwarded");
	a_flag_hold: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		ce_i && !soft_reset_bit && event_detected_flag_r[0] && sync_ch[0]
		&& !(wr && paddr_i == `EVR_OFF_FLAGS && pwdata_i[8]) |=> event_detected_flag_r[0])
		else $error("flag lost without clear");
	a_flag_clear: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		s_flag_wr(8) ##0 !det[0] |=> !event_detected_flag_r[0])
		else $error("flag not cleared");
	a_set_wins: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		s_flag_wr(8) ##0 det[0] |=> event_detected_flag_r[0])
		else $error("clear beat hardware set");
	a_ovr_clear: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		s_flag_wr(0) ##0 !det[0] |=> !overrun_flag_r[0])
		else $error("overrun flag not cleared");
	a_enclr_works: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		ce_i && wr && paddr_i == `EVR_OFF_ENCLR && pwdata_i[8] |=> !en_evd_r[0])
		else $error("enable not cleared");
	a_enable_hold: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		ce_i && !wr |=> $stable(en_evd_r) && $stable(en_ovr_r))
		else $error("enable changed without write");
	a_irq_ovr_src: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		ce_i && !soft_reset_bit && |(overrun_flag_r & en_ovr_r) |=> irq_o)
		else $error("overrun irq missing");
	a_wake_is_irq: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		wake_o == irq_o)
		else $error("wake differs from irq");
	a_soft_reset_bit_outputs: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		soft_reset_bit |=> !irq_o && chan_clk_req_o == '0 && busy_r == '0)
		else $error("soft reset left outputs active");
	a_soft_reset_bit_regs: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		soft_reset_bit |=> en_evd_r == '0 && event_detected_flag_r == '0
		&& user_mux_r == `EVR_RST_USER)
		else $error("soft reset left registers set");
	a_rd_enset: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		s_reg_rd(`EVR_OFF_ENSET) |=> prdata_o[`EVR_EVD_LSB +: NCH] == $past(en_evd_r))
		else $error("enable set readback wrong");
	a_rd_enclr: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		s_reg_rd(`EVR_OFF_ENCLR) |=> prdata_o[`EVR_OVR_LSB +: NCH] == $past(en_ovr_r))
		else $error("enable clear readback wrong");
	a_rd_flags: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		s_reg_rd(`EVR_OFF_FLAGS) |=> prdata_o[`EVR_EVD_LSB +: NCH]
		== $past(event_detected_flag_r))
		else $error("flag readback wrong");
	a_rd_status: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		s_reg_rd(`EVR_OFF_STAT) |=> prdata_o[8 +: NCH] == $past(busy_r))
		else $error("busy readback wrong");
endmodule

/* File: verification/evr_far_model.sv */
`timescale 1ns/1ps
// Generators toggle on request; users take an event and report it handled
// one cycle later, or hold it pending for as long as they are stalled.
module evr_far_model (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic arst_n_i,
	// Bench control
	input wire logic tog_i,
	input wire logic [7:0] tog_idx_i,
	input wire logic stall_i,
	// Event side
	input wire logic [7:0] chan_event_i,
	output logic [255:0] gen_lvl_o,
	output logic [7:0] users_ready_o,
	output logic [7:0] users_done_o
);
	logic [7:0] pend_r;
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			gen_lvl_o <= '0;
		end else if (tog_i) begin
			gen_lvl_o[tog_idx_i] <= ~gen_lvl_o[tog_idx_i];
		end
	end
	// A stalled user stays not ready, so a second event becomes an overrun.
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pend_r <= 8'h00;
		end else begin
			pend_r <= (pend_r | chan_event_i) & ~users_done_o;
		end
	end
	assign users_done_o = stall_i ? 8'h00 : pend_r;
	assign users_ready_o = ~pend_r;
endmodule

/* File: verification/testbench.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("[ERR] %0t got %h expected %h", $time, (g), (e)); end end
module testbench;
	logic mclk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic [31:0] rdata;
	logic pready, pslverr, slv, irq, wake;
	logic tog = 1'b0;
	logic stall = 1'b0;
	logic sleep = 1'b0;
	logic [7:0] tog_idx = 8'h00;
	logic [255:0] gen_lvl;
	logic [7:0] rdy, done, chev, creq;
	int mismatches = 0;
	int total_checks = 0;
	int cycles = 0;
	always #50 mclk_i = ~mclk_i;
	evr_irq_status evr_irq_status_inst (.mclk_i(mclk_i), .ce_i(1'b1), .arst_n_i(arst_n_i),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.gen_lvl_i(gen_lvl), .users_ready_i(rdy), .users_done_i(done),
		.sys_clk_stopped_i(sleep), .chan_event_o(chev), .chan_clk_req_o(creq),
		.irq_o(irq), .wake_o(wake));
	evr_far_model evr_far_model_inst (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .tog_i(tog),
		.tog_idx_i(tog_idx), .stall_i(stall), .chan_event_i(chev), .gen_lvl_o(gen_lvl),
		.users_ready_o(rdy), .users_done_o(done));
	task automatic tally_and_finish;
		if (mismatches == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk_i);
		penable <= 1'b1;
		do @(posedge mclk_i); while (pready !== 1'b1);
		rdata = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		`CHK(rdata, e)
	endtask
	task automatic pulse(input logic [7:0] g);
		repeat (2) begin
			@(posedge mclk_i);
			tog <= 1'b1;
			tog_idx <= g;
			@(posedge mclk_i);
			tog <= 1'b0;
		end
		repeat (3) @(posedge mclk_i);
	endtask
	initial begin
		repeat (8) @(posedge mclk_i);
		arst_n_i <= 1'b1;
		rd(12'h000, 32'h0000_0000);
		rd(12'h014, 32'h0000_0000);
		rd(12'h018, 32'h0000_0000);
		rd(12'h00c, 32'h0000_00ff);
		rd(12'h01c, 32'h0000_0000);
		`CHK(slv, 1'b1)
		apb(1'b1, 12'h014, 32'h0000_0101);
		rd(12'h010, 32'h0000_0101);
		apb(1'b1, 12'h010, 32'h0000_0001);
		rd(12'h014, 32'h0000_0100);
		apb(1'b1, 12'h004, 32'h0401_0000);
		pulse(8'h01);
		`CHK({irq, wake}, 2'b11)
		rd(12'h018, 32'h0000_0100);
		apb(1'b1, 12'h018, 32'h0000_0100);
		rd(12'h018, 32'h0000_0000);
		`CHK(irq, 1'b0)
		pulse(8'h01);
		apb(1'b1, 12'h010, 32'h0000_0100);
		rd(12'h018, 32'h0000_0100);
		`CHK(irq, 1'b0)
		apb(1'b1, 12'h018, 32'h0000_0100);
		stall <= 1'b1;
		sleep <= 1'b1;
		apb(1'b1, 12'h004, 32'h0501_0000);
		pulse(8'h01);
		`CHK(creq, 8'h01)
		rd(12'h00c, 32'h0000_01fe);
		pulse(8'h01);
		rd(12'h018, 32'h0000_0101);
		`CHK(irq, 1'b0)
		apb(1'b1, 12'h014, 32'h0000_0001);
		repeat (3) @(posedge mclk_i);
		`CHK(irq, 1'b1)
		stall <= 1'b0;
		repeat (4) @(posedge mclk_i);
		`CHK(creq, 8'h00)
		apb(1'b1, 12'h018, 32'h0000_0101);
		stall <= 1'b1;
		apb(1'b1, 12'h004, 32'h0202_0001);
		pulse(8'h02);
		pulse(8'h02);
		`CHK(creq, 8'h00)
		rd(12'h018, 32'h0000_0000);
		stall <= 1'b0;
		sleep <= 1'b0;
		apb(1'b1, 12'h004, 32'h0300_0002);
		apb(1'b1, 12'h000, 32'h0000_0010);
		repeat (3) @(posedge mclk_i);
		`CHK(creq, 8'hf9)
		rd(12'h000, 32'h0000_0010);
		pulse(8'h01);
		apb(1'b1, 12'h000, 32'h0000_0011);
		rd(12'h000, 32'h0000_0000);
		rd(12'h014, 32'h0000_0000);
		rd(12'h018, 32'h0000_0000);
		`CHK({irq, creq}, 9'h000)
		apb(1'b1, 12'h014, 32'h0000_0100);
		apb(1'b1, 12'h004, 32'h0000_0100);
		rd(12'h018, 32'h0000_0100);
		`CHK(irq, 1'b1)
		tally_and_finish();
	end
endmodule
